/* File: core/acp_pkg.sv */
// Package for the converter's two-wire result and channel port.
package acp_pkg;

  // ----------------------------------------------------------------
  // Bus addressing
  // ----------------------------------------------------------------
  // Pin-selected target address; the value is arbitrary.
  localparam logic [6:0] ACP_OWN_ADDR = 7'h24;
  // Shared address used to synchronise several converters.
  localparam logic [6:0] ACP_GLOBAL_ADDR = 7'h77;

  // ----------------------------------------------------------------
  // Word layout and counts
  // ----------------------------------------------------------------
  localparam logic [3:0] ACP_BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] ACP_RESULT_BYTES = 2'h3;
  localparam int ACP_SIGN_POS = 23;
  localparam int ACP_MSB_POS = 22;
  localparam logic [5:0] ACP_PAD_BITS = 6'h00;
  localparam logic [2:0] ACP_PREFIX_KEEP0 = 3'h0;
  localparam logic [2:0] ACP_PREFIX_KEEP1 = 3'h4;
  localparam logic [2:0] ACP_PREFIX_LOAD = 3'h5;
  // Channel 0 positive, channel 1 negative, differential.
  localparam logic [4:0] ACP_CHANNEL_RESET = 5'h00;
  localparam logic [15:0] ACP_CODE_POS_FS = 16'h0000;
  localparam logic [15:0] ACP_CODE_UNDER = 16'hFFFF;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Raw code handed over by the converter core at end of conversion.
  typedef struct packed {
    logic sign_flag;
    logic range_msb;
    logic [15:0] value;
  } acp_code_type;

  // Channel selection as seen by the input multiplexer.
  typedef struct packed {
    logic [3:0] pos_channel;
    logic [3:0] neg_channel;
    logic neg_is_common;
  } acp_mux_type;

  typedef enum logic [2:0] {
    ACP_IDLE,
    ACP_ADDR,
    ACP_ADDR_ACK,
    ACP_RD_BYTE,
    ACP_RD_ACK,
    ACP_WR_BYTE,
    ACP_WR_ACK,
    ACP_IGNORE
  } acp_state_type;

endpackage

/* File: core/acp_port.sv */
// Two-wire target port holding the conversion result and channel selection.
//
// Contract
// - Data line is only pulled low or released.
// - Works at standard and fast bus rates.
// - Target only; clock in, data two-way.
// - Start and stop framed by data edges.
// - Repeated start behaves exactly like a start.
// - Eight data bits then one acknowledge bit.
// - Acknowledge pulls low; refusal leaves released.
// - Data changes only while clock is low.
// - Address is seven bits plus direction bit.
// - Selected on its wired address, and on the global one for writes.
// - Refuse address while converting, else acknowledge.
// - Hold 24-bit result and 5-bit selection.
// - Three bytes read then new conversion starts.
// - Result shifted out MSB first, falling edges.
// - Bit 23 is the sign flag.
// - Bits 23 and 22 encode the range.
// - Sixteen two's-complement bits, then six zeros.
// - Overrange clamps to full-scale codes.
// - Selection byte: prefix, mode, parity, index.
// - Reset selects pair 0/1 and starts converting.
// - Prefix 000/100 keeps, 101 loads channel.
// - Differential adjacent pair or single-ended with common.
// - Stop after write or partial read converts.
// - Also answers writes to the shared global address.
`timescale 1ns/100ps
`default_nettype none

module acp_port (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic conv_done,
  input wire acp_pkg::acp_code_type conv_code,
  output logic conv_start,
  output logic conv_busy,
  output acp_pkg::acp_mux_type mux_select
);
  import acp_pkg::*;

  // ----------------------------------------------------------------
  // Link clock domain
  // ----------------------------------------------------------------
  // The bit is sampled on the true rising clock edge. It crosses through the
  // same two flops as the clock pin, so the synchronised rise and the bit
  // arrive together. A toggle is avoided because this domain has no reset.
  logic link_bit;

  // Capture of each bit on the controller's clock.
  always_ff @(posedge scl_clk) begin
    link_bit <= sda_in;
  end

  // ----------------------------------------------------------------
  // Pin and bit synchronisers
  // ----------------------------------------------------------------
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] bit_sync;
  logic scl_last;
  logic sda_last;

  // Two flops on every pin and on the crossing bit.
  always_ff @(posedge core_clk) begin
    scl_sync <= {scl_sync[0], scl_clk};
    sda_sync <= {sda_sync[0], sda_in};
    bit_sync <= {bit_sync[0], link_bit};
  end

  // History of the synchronised levels for edge detection.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      scl_last <= 1'b1;
      sda_last <= 1'b1;
    end else if (ce) begin
      scl_last <= scl_sync[1];
      sda_last <= sda_sync[1];
    end
  end

  // ----------------------------------------------------------------
  // Bus events
  // ----------------------------------------------------------------
  // Start and stop are data edges while the clock stays high; a repeated
  // start is the same event and is handled identically.
  wire start_seen = scl_sync[1] & scl_last & sda_last & ~sda_sync[1];
  wire stop_seen = scl_sync[1] & scl_last & ~sda_last & sda_sync[1];
  // Edge events are only meaningful between start and stop.
  wire rise_seen = ~scl_last & scl_sync[1];
  wire fall_seen = scl_last & ~scl_sync[1];
  wire rx_bit = bit_sync[1];

  // ----------------------------------------------------------------
  // Protocol state
  // ----------------------------------------------------------------
  acp_state_type state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [23:0] tx_shift;
  logic [1:0] byte_cnt;
  logic master_nak;
  logic dir_read;
  logic written;
  logic pending;
  logic [4:0] channel_select;
  logic [23:0] conversion_result;
  logic fire_conv;

  // Address decode on the received address byte.
  wire [6:0] rx_addr = rx_shift[7:1];
  wire own_hit = (rx_addr == ACP_OWN_ADDR);
  // The shared address only accepts writes; a global read has no owner.
  wire global_hit = (rx_addr == ACP_GLOBAL_ADDR) & ~rx_shift[0];
  wire addr_ok = (own_hit | global_hit) & ~conv_busy;
  wire byte_full = (bit_cnt == ACP_BITS_PER_BYTE);
  wire [2:0] prefix = rx_shift[7:5];
  wire load_channel = (prefix == ACP_PREFIX_LOAD);
  wire last_byte = (byte_cnt == ACP_RESULT_BYTES);

  // Result word: sign and range bits, sixteen code bits, zero pad.
  // Clamped codes are forced from the range bits so a misbehaving core
  // cannot hand out a value outside the documented overrange codes.
  wire over_range = conv_code.sign_flag & conv_code.range_msb;
  wire under_range = ~conv_code.sign_flag & ~conv_code.range_msb;
  wire [15:0] code_clamped = over_range ? ACP_CODE_POS_FS :
    (under_range ? ACP_CODE_UNDER : conv_code.value);
  wire [23:0] next_result = {conv_code.sign_flag, conv_code.range_msb,
    code_clamped, ACP_PAD_BITS};

  // Main bus sequencer; all data line changes happen after a falling
  // clock edge, so the line is steady whenever the clock is high.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state <= ACP_IDLE;
      bit_cnt <= 4'h0;
      rx_shift <= 8'h00;
      tx_shift <= 24'h000000;
      byte_cnt <= 2'h0;
      master_nak <= 1'b0;
      dir_read <= 1'b0;
      written <= 1'b0;
      pending <= 1'b0;
      channel_select <= ACP_CHANNEL_RESET;
      sda_oe_n <= 1'b1;
      fire_conv <= 1'b0;
    end else if (ce) begin
      fire_conv <= 1'b0;
      if (start_seen) begin
        state <= ACP_ADDR;
        bit_cnt <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (stop_seen) begin
        // A stop after a write or a partial read starts converting.
        fire_conv <= pending;
        pending <= 1'b0;
        state <= ACP_IDLE;
        sda_oe_n <= 1'b1;
      end else begin
        case (state)
          ACP_ADDR, ACP_WR_BYTE: begin
            if (rise_seen && !byte_full) begin
              rx_shift <= {rx_shift[6:0], rx_bit};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (fall_seen && byte_full) begin
              if (state == ACP_ADDR) begin
                dir_read <= rx_shift[0];
                state <= addr_ok ? ACP_ADDR_ACK : ACP_IGNORE;
                sda_oe_n <= ~addr_ok;
              end else if (!written) begin
                // The selection is one byte; later bytes are refused.
                written <= 1'b1;
                pending <= 1'b1;
                if (load_channel) begin
                  channel_select <= rx_shift[4:0];
                end
                state <= ACP_WR_ACK;
                sda_oe_n <= 1'b0;
              end else begin
                state <= ACP_IGNORE;
              end
            end
          end
          ACP_ADDR_ACK, ACP_WR_ACK: begin
            if (fall_seen) begin
              bit_cnt <= 4'h0;
              if (state == ACP_ADDR_ACK && dir_read) begin
                tx_shift <= conversion_result;
                byte_cnt <= 2'h0;
                pending <= 1'b1;
                state <= ACP_RD_BYTE;
                sda_oe_n <= conversion_result[ACP_SIGN_POS];
              end else begin
                written <= (state == ACP_WR_ACK);
                state <= ACP_WR_BYTE;
                sda_oe_n <= 1'b1;
              end
            end
          end
          ACP_RD_BYTE: begin
            if (rise_seen && !byte_full) begin
              tx_shift <= {tx_shift[22:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (fall_seen) begin
              if (byte_full) begin
                // Release for the controller's acknowledge.
                byte_cnt <= byte_cnt + 2'h1;
                state <= ACP_RD_ACK;
                sda_oe_n <= 1'b1;
              end else begin
                sda_oe_n <= tx_shift[ACP_SIGN_POS];
              end
            end
          end
          ACP_RD_ACK: begin
            if (rise_seen) begin
              master_nak <= rx_bit;
            end else if (fall_seen) begin
              bit_cnt <= 4'h0;
              if (last_byte) begin
                // Whole word out: convert at once, no stop needed.
                fire_conv <= 1'b1;
                pending <= 1'b0;
                state <= ACP_IGNORE;
              end else if (master_nak) begin
                state <= ACP_IGNORE;
              end else begin
                state <= ACP_RD_BYTE;
                sda_oe_n <= tx_shift[ACP_SIGN_POS];
              end
            end
          end
          default: begin
            // Idle or not addressed: the line stays released.
            sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Conversion control
  // ----------------------------------------------------------------
  // Reset counts as one request so the first conversion runs on its own.
  logic first_conv;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      first_conv <= 1'b1;
      conv_start <= 1'b0;
      conv_busy <= 1'b1;
      conversion_result <= 24'h000000;
    end else if (ce) begin
      first_conv <= 1'b0;
      conv_start <= fire_conv | first_conv;
      if (fire_conv) begin
        conv_busy <= 1'b1;
      end else if (conv_done) begin
        conv_busy <= 1'b0;
        conversion_result <= next_result;
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel mapping
  // ----------------------------------------------------------------
  // Fields: mode flag, parity bit, three index bits.
  wire single_ended_flag = channel_select[4];
  wire parity_bit = channel_select[3];
  wire [2:0] channel_index = channel_select[2:0];
  wire [3:0] even_ch = {channel_index, 1'b0};
  wire [3:0] odd_ch = {channel_index, 1'b1};
  wire [3:0] next_pos = parity_bit ? odd_ch : even_ch;
  wire [3:0] next_neg = parity_bit ? even_ch : odd_ch;

  // Registered multiplexer selection for the converter core.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      mux_select <= '{pos_channel: 4'h0, neg_channel: 4'h1, neg_is_common: 1'b0};
    end else if (ce) begin
      mux_select.pos_channel <= next_pos;
      mux_select.neg_channel <= single_ended_flag ? 4'h0 : next_neg;
      mux_select.neg_is_common <= single_ended_flag;
    end
  end

  // The data line is only ever pulled low; the high level is the pull-up.
  always_ff @(posedge core_clk) begin
    sda_out <= 1'b0;
  end

endmodule

`default_nettype wire

/* File: sim/acp_port_asserts.sv */
// Concurrent checks on the converter port's pins.
`timescale 1ns/100ps
`default_nettype none
module acp_port_asserts (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic scl_clk,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic conv_done,
  input wire acp_pkg::acp_code_type conv_code,
  input wire logic conv_start,
  input wire logic conv_busy,
  input wire acp_pkg::acp_mux_type mux_select
);
  import acp_pkg::*;
  // ----------------------------------------------------------------
  // Pin relations
  // ----------------------------------------------------------------
  // All checks use the core clock; the bus clock is only a sampled level here.
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_SDA_LOW: assert property (sda_out == 1'h0)
    else $error("data line value not low");
  AST_OE_SCL_LOW: assert property (!$stable(sda_oe_n) |-> !scl_clk)
    else $error("data drive changed with bus clock high");
  AST_BUSY_QUIET: assert property (conv_busy |-> sda_oe_n)
    else $error("data line pulled while converting");
  AST_RST_MUX: assert property ($rose(nrst) |-> mux_select == 9'h002)
    else $error("wrong channel pair after reset");
  AST_RST_START: assert property ($rose(nrst) && ce |=> conv_start)
    else $error("no conversion after reset");
  AST_START_PULSE: assert property (conv_start |=> !conv_start && conv_busy)
    else $error("start not a single pulse into busy");
  AST_DONE_IDLE: assert property (conv_done |-> ##[1:3] !conv_busy)
    else $error("busy stuck after done");
  AST_MUX_HOLD: assert property (!$stable(mux_select) |-> !conv_busy)
    else $error("channel changed during conversion");
  // Main scenarios: the controller pulling data low while converting, an acknowledge, a new conversion.
  cover property (conv_busy && !scl_clk && !sda_in);
  cover property (!sda_oe_n && !conv_busy);
  cover property (conv_start ##1 conv_busy);
endmodule

bind acp_port acp_port_asserts u_acp_port_asserts (
  .core_clk(core_clk), .nrst(nrst), .ce(ce), .scl_clk(scl_clk), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .conv_done(conv_done), .conv_code(conv_code),
  .conv_start(conv_start), .conv_busy(conv_busy), .mux_select(mux_select)
);
`default_nettype wire

/* File: sim/acp_host_model.sv */
// Bus controller model driving the port from the far side of the wire.
`timescale 1ns/100ps
`default_nettype none
module acp_host_model #(
  parameter int HALF = 12
) (
  input wire logic link_clk,
  input wire logic sda_line,
  output var logic scl_clk,
  output var logic host_oe_n
);
  import acp_pkg::*;
  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  // Both lines idle released; the bus clock stands still between frames.
  initial begin
    scl_clk = 1'h1;
    host_oe_n = 1'h1;
  end
  // A third of a bit time, long enough for the port's synchroniser to follow.
  task automatic half();
    repeat (HALF) @(posedge link_clk);
  endtask
  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    half();
    host_oe_n = 1'h1;
    half();
    scl_clk = 1'h1;
    half();
    host_oe_n = 1'h0;
    half();
    scl_clk = 1'h0;
  endtask
  // Stop: data rises while the clock is high.
  task automatic stop();
    half();
    host_oe_n = 1'h0;
    half();
    scl_clk = 1'h1;
    half();
    host_oe_n = 1'h1;
    half();
  endtask
  // One bit: data set mid low phase, sampled while the clock is high.
  task automatic bit1(input logic b, output logic r);
    half();
    host_oe_n = b;
    half();
    scl_clk = 1'h1;
    half();
    r = sda_line;
    scl_clk = 1'h0;
  endtask
  // Eight data bits, most significant first, then the acknowledge slot.
  task automatic xfer(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
                      output logic ack_rx);
    for (int i = 7; i >= 0; i--) bit1(tx[i], rx[i]);
    bit1(ack_tx, ack_rx);
  endtask
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the converter's two-wire port.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import acp_pkg::*;
  logic core_clk = 1'h0;
  logic link_clk = 1'h0;
  logic nrst = 1'h0;
  logic conv_done = 1'h0;
  logic scl_clk, host_oe_n, sda_out, sda_oe_n, conv_start, conv_busy, ack;
  logic [7:0] rx;
  logic [9:0] cnt = 10'h000;
  acp_code_type conv_code = 18'h00000;
  acp_mux_type mux_select;
  acp_code_type codes[4] = '{18'h3_1234, 18'h0_1234, 18'h2_7FFF, 18'h1_8000};
  logic [7:0] wbyte[5] = '{8'hBA, 8'h83, 8'hAB, 8'h1F, 8'hA2};
  logic [8:0] wmux[5] = '{9'h0A1, 9'h0A1, 9'h0EC, 9'h0EC, 9'h08A};
  int mismatches = 0;
  int checked = 0;
  // Pull-up wire: low whenever either party pulls.
  wire logic sda_line = host_oe_n & sda_oe_n;
  // Core clock, and a link base clock of unrelated rate.
  always #50 core_clk = ~core_clk;
  always #62.5 link_clk = ~link_clk;
  acp_port u_acp_port (.core_clk(core_clk), .nrst(nrst), .ce(1'h1), .scl_clk(scl_clk),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .conv_done(conv_done),
    .conv_code(conv_code), .conv_start(conv_start), .conv_busy(conv_busy),
    .mux_select(mux_select));
  acp_host_model u_acp_host_model (.link_clk(link_clk), .sda_line(sda_line),
    .scl_clk(scl_clk), .host_oe_n(host_oe_n));
  // Converter stand-in; long enough that a first address lands while busy.
  always @(negedge core_clk) begin
    conv_done <= 1'h0;
    if (conv_start) cnt <= 10'h3E8;
    else if (cnt != 10'h000) cnt <= cnt - 10'h001;
    if (cnt == 10'h001) conv_done <= 1'h1;
  end
  task automatic test_done();
    if (mismatches == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_ack(input logic exp);
    chk({8'h00, ack}, {8'h00, exp});
  endtask
  // Bounded wait for the end of a conversion; a hang ends the run.
  task automatic wait_idle();
    for (int i = 0; i < 2000 && conv_busy !== 1'h0; i++) @(negedge core_clk);
    if (conv_busy !== 1'h0) begin
      mismatches++;
      test_done();
    end
  endtask
  task automatic addr(input logic [6:0] a, input logic rd);
    u_acp_host_model.start();
    u_acp_host_model.xfer({a, rd}, 1'h1, rx, ack);
  endtask
  // Full read; over- and underrange clamp the value field.
  task automatic rd3(input acp_code_type c);
    logic [23:0] w;
    w = {c.sign_flag, c.range_msb, c.value, 6'h00};
    if (c.sign_flag == c.range_msb) w[21:6] = c.sign_flag ? 16'h0000 : 16'hFFFF;
    addr(ACP_OWN_ADDR, 1'h1);
    chk_ack(1'h0);
    for (int b = 2; b >= 0; b--) begin
      u_acp_host_model.xfer(8'hFF, b == 0, rx, ack);
      chk({1'h0, rx}, {1'h0, w[b*8 +: 8]});
    end
    u_acp_host_model.stop();
    chk({8'h00, conv_busy}, 9'h001);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic [8:0] m);
    addr(a, 1'h0);
    chk_ack(1'h0);
    u_acp_host_model.xfer(d, 1'h1, rx, ack);
    chk_ack(1'h0);
    u_acp_host_model.stop();
    chk(mux_select, m);
    chk({8'h00, conv_busy}, 9'h001);
  endtask
  initial begin
    repeat (2) @(negedge core_clk);
    nrst = 1'h1;
    repeat (4) @(negedge core_clk);
    chk(mux_select, 9'h002);
    addr(ACP_OWN_ADDR, 1'h1);
    chk_ack(1'h1);
    u_acp_host_model.stop();
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk);
      conv_code = codes[i];
      wait_idle();
      rd3(codes[i]);
    end
    wait_idle();
    addr(7'h25, 1'h0);
    chk_ack(1'h1);
    u_acp_host_model.stop();
    addr(ACP_GLOBAL_ADDR, 1'h1);
    chk_ack(1'h1);
    u_acp_host_model.stop();
    chk({8'h00, conv_busy}, 9'h000);
    for (int i = 0; i < 5; i++) begin
      wait_idle();
      wr(i == 1 ? ACP_GLOBAL_ADDR : ACP_OWN_ADDR, wbyte[i], wmux[i]);
    end
    wait_idle();
    addr(ACP_OWN_ADDR, 1'h0);
    u_acp_host_model.xfer(8'hBA, 1'h1, rx, ack);
    addr(ACP_OWN_ADDR, 1'h1);
    chk_ack(1'h0);
    u_acp_host_model.xfer(8'hFF, 1'h1, rx, ack);
    chk({1'h0, rx}, 9'h060);
    u_acp_host_model.stop();
    chk({8'h00, conv_busy}, 9'h001);
    chk(mux_select, 9'h0A1);
    wait_idle();
    test_done();
  end
endmodule
`default_nettype wire
